// ==== rtl/line_term_pkg.sv ====
// Constants for the line termination control block.
// Assumes a single 25 MHz clock and a simple same-clock register port.
package line_term_pkg;
    // ***********************************************
    // Register offsets
    // ***********************************************
    localparam logic [7:0] CTRL_ONE_OFFSET = 8'h01;
    localparam logic [7:0] CTRL_THREE_OFFSET = 8'h03;
    localparam logic [7:0] HANDOVER_OFFSET = 8'h12;

    // ***********************************************
    // Field positions
    // ***********************************************
    localparam int RX_TERM_BIT = 7;
    localparam int TX_TERM_BIT = 6;
    localparam int IMP_HIGH_BIT = 5;
    localparam int IMP_LOW_BIT = 4;
    localparam int RATIO_BIT = 0;
    localparam int TX_ON_BIT = 1;
    localparam int TX_ON_HANDOVER_BIT = 5;
    localparam int RX_TERM_HANDOVER_BIT = 4;

    // ***********************************************
    // Reset values (all external, transmitter off)
    // ***********************************************
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
    localparam logic [7:0] HANDOVER_RESET = 8'h00;

    // ***********************************************
    // Impedance codes and internal resistance
    // ***********************************************
    // Resistance is reported in quarter ohms
    localparam logic [1:0] IMP_T1_100 = 2'h0;
    localparam logic [1:0] IMP_J1_110 = 2'h1;
    localparam logic [1:0] IMP_E1_75 = 2'h2;
    localparam logic [1:0] IMP_E1_120 = 2'h3;
    localparam logic [6:0] RINT_T1_Q = 7'h64;
    localparam logic [6:0] RINT_J1_Q = 7'h6E;
    localparam logic [6:0] RINT_E1_75_Q = 7'h4B;
    localparam logic [6:0] RINT_E1_120_Q = 7'h78;
    localparam logic [6:0] RINT_NONE_Q = 7'h00;
    // Line impedance in ohms per code
    localparam logic [6:0] LINE_100_OHM = 7'h64;
    localparam logic [6:0] LINE_110_OHM = 7'h6E;
    localparam logic [6:0] LINE_75_OHM = 7'h4B;
    localparam logic [6:0] LINE_120_OHM = 7'h78;
endpackage

// ==== rtl/line_termination_control.sv ====
// Line termination control: selects transmit and receive termination,
// impedance, turns ratio and transmit on/off from straps or host registers.
// Assumes straps and pins are asynchronous; register port is on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module line_termination_control
    import line_term_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Mode strap and hardware pins
    input wire logic host_mode_i,
    input wire logic tx_termination_select_i,
    input wire logic rx_termination_select_i,
    input wire logic impedance_code_high_i,
    input wire logic impedance_code_low_i,
    input wire logic turns_ratio_select_i,
    input wire logic transmit_on_pin_i,
    // Register port
    input wire logic reg_we_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Termination controls
    output logic tx_int_term_en_o,
    output logic rx_int_term_en_o,
    output logic ratio_245_o,
    output logic [1:0] impedance_code_o,
    output logic [6:0] line_ohms_o,
    output logic [6:0] tx_rint_qohm_o,
    output logic tx_output_on_o
);
    // ***********************************************
    // Elaboration check
    // ***********************************************
    // Fewer than two stages would let metastability reach logic
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // ***********************************************
    // Functions
    // ***********************************************
    // Internal transmit resistance for an impedance code
    function automatic logic [6:0] rint_of(input logic [1:0] code);
        logic [6:0] r;
        r = RINT_T1_Q;
        case (code)
            IMP_J1_110: r = RINT_J1_Q;
            IMP_E1_75: r = RINT_E1_75_Q;
            IMP_E1_120: r = RINT_E1_120_Q;
            default: r = RINT_T1_Q;
        endcase
        return r;
    endfunction

    // Line impedance in ohms for an impedance code
    function automatic logic [6:0] ohms_of(input logic [1:0] code);
        logic [6:0] o;
        o = LINE_100_OHM;
        case (code)
            IMP_J1_110: o = LINE_110_OHM;
            IMP_E1_75: o = LINE_75_OHM;
            IMP_E1_120: o = LINE_120_OHM;
            default: o = LINE_100_OHM;
        endcase
        return o;
    endfunction

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    localparam int NPINS = 7;
    logic [NPINS-1:0] pins_raw; // Asynchronous pin levels
    logic [NPINS-1:0] sync_r [SYNC_STAGES]; // Chain, stage 0 first
    logic [NPINS-1:0] pins_q; // Safe to read

    assign pins_raw = {host_mode_i, tx_termination_select_i,
                       rx_termination_select_i, impedance_code_high_i,
                       impedance_code_low_i, turns_ratio_select_i,
                       transmit_on_pin_i};
    assign pins_q = sync_r[SYNC_STAGES-1];

    // Shift chain; stage 0 feeds only stage 1
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_r[i] <= '0;
            end
        end else if (clk_en_i) begin
            sync_r[0] <= pins_raw;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_r[i] <= sync_r[i-1];
            end
        end
    end

    logic host_q; // Host mode strap
    logic txsel_q; // Transmit termination strap
    logic rxsel_q; // Receive termination strap
    logic [1:0] imp_q; // Impedance strap pair
    logic ratio_q; // Turns ratio strap
    logic transmit_on_pin_q; // Transmit on pin
    assign host_q = pins_q[6];
    assign txsel_q = pins_q[5];
    assign rxsel_q = pins_q[4];
    assign imp_q = pins_q[3:2];
    assign ratio_q = pins_q[1];
    assign transmit_on_pin_q = pins_q[0];

    // ***********************************************
    // Host registers
    // ***********************************************
    logic [7:0] ctrl_one_r; // Termination and impedance
    logic [7:0] ctrl_three_r; // Ratio and transmit on
    logic [7:0] handover_r; // Pin handover bits

    // Control one written by host
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_one_r <= CTRL_ONE_RESET;
        end else if (clk_en_i && reg_we_i && reg_addr_i == CTRL_ONE_OFFSET) begin
            ctrl_one_r <= reg_wdata_i;
        end
    end

    // Control three written by host
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_three_r <= CTRL_THREE_RESET;
        end else if (clk_en_i && reg_we_i && reg_addr_i == CTRL_THREE_OFFSET) begin
            ctrl_three_r <= reg_wdata_i;
        end
    end

    // Handover register written by host
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            handover_r <= HANDOVER_RESET;
        end else if (clk_en_i && reg_we_i && reg_addr_i == HANDOVER_OFFSET) begin
            handover_r <= reg_wdata_i;
        end
    end

    // Read data; unmapped offsets read zero
    logic [7:0] rdata_nxt;
    always_comb begin
        if (reg_addr_i == CTRL_ONE_OFFSET) begin
            rdata_nxt = ctrl_one_r;
        end else if (reg_addr_i == CTRL_THREE_OFFSET) begin
            rdata_nxt = ctrl_three_r;
        end else if (reg_addr_i == HANDOVER_OFFSET) begin
            rdata_nxt = handover_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // ***********************************************
    // Source selection
    // ***********************************************
    logic tx_int_nxt; // Internal transmit termination
    logic rx_int_nxt; // Internal receive termination
    logic [1:0] imp_nxt; // Active impedance code
    logic ratio_nxt; // Ratio, 1 means 1:2.45
    logic transmit_on_pin_nxt; // Transmitter enabled

    always_comb begin
        // Pins drive everything outside host mode
        // strap selects termination
        tx_int_nxt = txsel_q;
        rx_int_nxt = rxsel_q;
        imp_nxt = imp_q;
        ratio_nxt = ratio_q;
        transmit_on_pin_nxt = transmit_on_pin_q;
        if (host_q) begin
            tx_int_nxt = ctrl_one_r[TX_TERM_BIT];
            imp_nxt = {ctrl_one_r[IMP_HIGH_BIT], ctrl_one_r[IMP_LOW_BIT]};
            ratio_nxt = ctrl_three_r[RATIO_BIT];
            if (handover_r[TX_ON_HANDOVER_BIT]) begin
                transmit_on_pin_nxt = transmit_on_pin_q;
            end else begin
                transmit_on_pin_nxt = ctrl_three_r[TX_ON_BIT];
            end
            if (handover_r[RX_TERM_HANDOVER_BIT]) begin
                rx_int_nxt = rxsel_q;
            end else begin
                rx_int_nxt = ctrl_one_r[RX_TERM_BIT];
            end
        end
        if (tx_int_nxt) begin
            ratio_nxt = 1'b0;
        end
    end

    // ***********************************************
    // Output registers
    // ***********************************************
    // Registered so straps never glitch analog controls
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_int_term_en_o <= 1'b0;
            rx_int_term_en_o <= 1'b0;
            ratio_245_o <= 1'b0;
            impedance_code_o <= IMP_T1_100;
            line_ohms_o <= LINE_100_OHM;
            tx_output_on_o <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            tx_int_term_en_o <= tx_int_nxt;
            rx_int_term_en_o <= rx_int_nxt;
            ratio_245_o <= ratio_nxt;
            impedance_code_o <= imp_nxt;
            line_ohms_o <= ohms_of(imp_nxt);
            tx_output_on_o <= transmit_on_pin_nxt;
            reg_rdata_o <= rdata_nxt;
        end
    end

    // Internal resistance, zero when external
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_rint_qohm_o <= RINT_NONE_Q;
        end else if (clk_en_i) begin
            tx_rint_qohm_o <= tx_int_nxt ? rint_of(imp_nxt) : RINT_NONE_Q;
        end
    end

    // ***********************************************
    // Assertions
    // ***********************************************
    // Registered outputs are checked one edge after their sources
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_hw_tx_strap: assert property (clk_en_i && !host_q |=>
        tx_int_term_en_o == $past(txsel_q))
        else $error("hardware transmit termination mismatch");
    a_host_tx_bit: assert property (clk_en_i && host_q |=>
        tx_int_term_en_o == $past(ctrl_one_r[TX_TERM_BIT]))
        else $error("host transmit termination mismatch");
    a_reset_external: assert property ($rose(rst_b_i) |->
        !tx_int_term_en_o && tx_rint_qohm_o == RINT_NONE_Q)
        else $error("not external after reset");
    a_int_ratio: assert property (tx_int_term_en_o |-> !ratio_245_o)
        else $error("internal mode not at 1:2");
    a_ext_no_rint: assert property (!tx_int_term_en_o |->
        tx_rint_qohm_o == RINT_NONE_Q)
        else $error("internal resistance while external");
    a_imp_decode: assert property (line_ohms_o ==
        (impedance_code_o == IMP_T1_100 ? LINE_100_OHM :
        impedance_code_o == IMP_J1_110 ? LINE_110_OHM :
        impedance_code_o == IMP_E1_75 ? LINE_75_OHM : LINE_120_OHM))
        else $error("impedance decode wrong");
    a_ext_ratio: assert property (clk_en_i && host_q && !tx_int_nxt |=>
        ratio_245_o == $past(ctrl_three_r[RATIO_BIT]))
        else $error("external ratio mismatch");
    a_rint_code: assert property (tx_int_term_en_o |->
        tx_rint_qohm_o == (impedance_code_o == IMP_T1_100 ? RINT_T1_Q :
        impedance_code_o == IMP_J1_110 ? RINT_J1_Q :
        impedance_code_o == IMP_E1_75 ? RINT_E1_75_Q : RINT_E1_120_Q))
        else $error("internal resistance wrong");
    a_transmit_on_pin_pin: assert property (clk_en_i && host_q &&
        handover_r[TX_ON_HANDOVER_BIT] |=> tx_output_on_o == $past(transmit_on_pin_q))
        else $error("transmit on not from pin");
    a_rx_pin: assert property (clk_en_i && host_q &&
        handover_r[RX_TERM_HANDOVER_BIT] |=> rx_int_term_en_o == $past(rxsel_q))
        else $error("receive termination not from pin");
    a_rx_host_bit: assert property (clk_en_i && host_q &&
        !handover_r[RX_TERM_HANDOVER_BIT] |=>
        rx_int_term_en_o == $past(ctrl_one_r[RX_TERM_BIT]))
        else $error("receive termination not from register");
    a_transmit_on_pin_reg: assert property (clk_en_i && host_q &&
        !handover_r[TX_ON_HANDOVER_BIT] |=>
        tx_output_on_o == $past(ctrl_three_r[TX_ON_BIT]))
        else $error("transmit on not from register");

    // Main scenarios worth seeing at least once
    c_hw_internal_e1: cover property (!host_q && tx_int_term_en_o
        && impedance_code_o == IMP_E1_75);
    c_rx_handover: cover property (host_q && handover_r[RX_TERM_HANDOVER_BIT]
        && rx_int_term_en_o);
    c_host_internal: cover property (host_q && tx_int_term_en_o);
    c_hw_ratio_245: cover property (!host_q && ratio_245_o);
    c_transmit_on_pin_handover: cover property (host_q && handover_r[TX_ON_HANDOVER_BIT]
        && tx_output_on_o);
endmodule
`default_nettype wire

// ==== sim/host_strap_model.sv ====
// Host processor and board strap model facing the termination control block.
// Assumes the block samples its register port and pins on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_strap_model (
    input wire logic core_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic host_mode_o,
    output logic [5:0] pins_o,
    output logic reg_we_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // ****************************************
    // Idle levels
    // ****************************************
    // Pins order: tx sel, rx sel, imp high, imp low, ratio, transmit on
    initial begin
        host_mode_o = 1'b1;
        pins_o = 6'h3F;
        reg_we_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // Straps move only on the falling edge
    task automatic set_pins(input logic hm, input logic [5:0] p);
        @(negedge core_clk_i);
        host_mode_o = hm;
        pins_o = p;
    endtask

    // One-cycle strobe; data inverted after so stale data never matches
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_we_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge core_clk_i);
        reg_we_o = 1'b0;
        reg_wdata_o = ~d;
    endtask

    // Read data is registered, so it is taken one cycle later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o = a;
        @(negedge core_clk_i);
        d = reg_rdata_i;
    endtask

    // redundancy card setup
    // Backup transmitter off; receiver active unless 1:1 backup
    task automatic set_card(input logic backup, input logic line_prot, input logic [1:0] c);
        write_reg(8'h12, 8'h00);
        write_reg(8'h01, {(!backup || line_prot), 1'b1, c, 4'h0});
        write_reg(8'h03, {6'h00, !backup, 1'b0});
    endtask
endmodule
`default_nettype wire

// ==== sim/line_termination_control_bench.sv ====
// Self-checking bench for the line termination control block.
// Assumes the host_strap_model partner and the line_term_pkg package.
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module line_termination_control_bench;
    import line_term_pkg::*;
    logic core_clk, rst_b, clk_en, host_mode, we;
    logic [5:0] pins;
    logic [7:0] addr, wdata, rdata, rd;
    wire logic [19:0] outs;
    logic [31:0] lfsr_s = 32'h9BB02CB7; // Random state
    int failures = 0;
    int checks = 0;
    int c1, c3, ho; // Shadow copies of the three registers
    byte unsigned addrs[$] = '{8'h01, 8'h03, 8'h12, 8'h55};

    // ****************************************
    // Clock, partner and design
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    host_strap_model host_strap_model_i (.core_clk_i(core_clk), .reg_rdata_i(rdata),
        .host_mode_o(host_mode), .pins_o(pins), .reg_we_o(we), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    line_termination_control line_termination_control_i (.core_clk_i(core_clk),
        .rst_b_i(rst_b), .clk_en_i(clk_en), .host_mode_i(host_mode),
        .tx_termination_select_i(pins[5]), .rx_termination_select_i(pins[4]),
        .impedance_code_high_i(pins[3]), .impedance_code_low_i(pins[2]),
        .turns_ratio_select_i(pins[1]), .transmit_on_pin_i(pins[0]), .reg_we_i(we),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .tx_int_term_en_o(outs[19]), .rx_int_term_en_o(outs[18]), .ratio_245_o(outs[17]),
        .impedance_code_o(outs[16:15]), .line_ohms_o(outs[14:8]),
        .tx_rint_qohm_o(outs[7:1]), .tx_output_on_o(outs[0]));

    // ****************************************
    // Reference model
    // ****************************************
    // Internal resistance kept in quarter ohms, equal to the line figure
    function automatic logic [19:0] expect_out(int hm, int p);
        int ohm[4] = '{100, 110, 75, 120};
        int tx, rx, code, rat, on;
        tx = hm ? (c1 >> 6) & 1 : (p >> 5) & 1;
        rx = (hm && !((ho >> 4) & 1)) ? (c1 >> 7) & 1 : (p >> 4) & 1;
        code = hm ? (c1 >> 4) & 3 : (p >> 2) & 3;
        rat = tx ? 0 : (hm ? c3 & 1 : (p >> 1) & 1);
        on = (hm && !((ho >> 5) & 1)) ? (c3 >> 1) & 1 : p & 1;
        return {tx[0], rx[0], rat[0], code[1:0], ohm[code][6:0],
            (tx ? ohm[code][6:0] : 7'h00), on[0]};
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Write through the partner and track mapped registers only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_strap_model_i.write_reg(a, d);
        if (a == 8'h01) c1 = d;
        else if (a == 8'h03) c3 = d;
        else if (a == 8'h12) ho = d;
    endtask

    // Pins cross two sync stages plus an output register; 5 leaves margin
    task automatic settle_check();
        logic [19:0] exp_o;
        repeat (5) @(negedge core_clk);
        exp_o = expect_out(host_mode, pins);
        `CHECK_EQ(outs[19:18], exp_o[19:18])
        `CHECK_EQ(outs[17:8], exp_o[17:8])
        `CHECK_EQ(outs[7:0], exp_o[7:0])
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    // About 1040 cycles expected; fourteen times that is a hang
    initial begin
        repeat (15000) @(posedge core_clk);
        failures++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        c1 = 0;
        c3 = 0;
        ho = 0;
        repeat (3) @(negedge core_clk);
        // Straps all high and host mode during reset must not leak out
        `CHECK_EQ(outs, expect_out(0, 0))
        rst_b = 1'b1;
        // Handover bits set but ignored in hardware mode
        wr(8'h12, 8'h30);
        for (int p = 0; p < 64; p++) begin
            host_strap_model_i.set_pins(1'b0, p[5:0]);
            settle_check();
        end
        // Readback of every mapped offset, unmapped reads as zero
        foreach (addrs[i]) begin
            lfsr_s = lfsr_next(lfsr_s);
            wr(addrs[i], lfsr_s[7:0]);
            host_strap_model_i.read_reg(addrs[i], rd);
            `CHECK_EQ(rd, (addrs[i] == 8'h55) ? 8'h00 : lfsr_s[7:0])
        end
        // Host mode with random registers, handovers and pins
        for (int n = 0; n < 48; n++) begin
            lfsr_s = lfsr_next(lfsr_s);
            wr(8'h01, lfsr_s[7:0]);
            wr(8'h03, lfsr_s[15:8]);
            wr(8'h12, lfsr_s[23:16]);
            host_strap_model_i.set_pins(1'b1, lfsr_s[29:24]);
            settle_check();
        end
        // Clock enable low: a write must be dropped
        clk_en = 1'b0;
        host_strap_model_i.write_reg(8'h01, ~c1[7:0]);
        clk_en = 1'b1;
        settle_check();
        // Redundancy setups for primary and backup cards
        for (int k = 0; k < 4; k++) begin
            host_strap_model_i.set_card(k[0], k[1], k[1:0]);
            c1 = {(!k[0] || k[1]), 1'b1, k[1:0], 4'h0};
            c3 = {6'h00, !k[0], 1'b0};
            ho = 0;
            settle_check();
        end
        // Second reset in mid-run returns to external defaults
        @(negedge core_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHECK_EQ(outs, expect_out(0, 0))
        rst_b = 1'b1;
        c1 = 0;
        c3 = 0;
        ho = 0;
        settle_check();
        host_strap_model_i.read_reg(8'h01, rd);
        `CHECK_EQ(rd, CTRL_ONE_RESET)
        print_verdict();
    end
endmodule
`default_nettype wire
